// ===== core/spc_params.svh
// pin count and reset constants for the standby pin state control block
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH
`define SPC_NUM_PINS       8
`define SPC_RST_OUT        1'h0
`define SPC_RST_OE         1'h0
`define SPC_RST_PU         1'h0
`define SPC_RST_IN         1'h0
`endif

// ===== core/spc_pkg.sv
// types shared by the standby pin state control block
package spc_pkg;
  // power states, one-hot
  typedef enum logic [4:0] {
    SPC_RUN   = 5'h01,
    SPC_SLEEP = 5'h02,
    SPC_STOP  = 5'h04,
    SPC_WATCH = 5'h08,
    SPC_RESET = 5'h10
  } spc_mode_e;
  // per-pin drive request from the port or peripheral logic
  typedef struct packed {
    logic out;
    logic oe;
    logic pu;
  } spc_drive_s;
  // per-pin pad drive towards the board
  typedef struct packed {
    logic out;
    logic oe;
    logic pu;
  } spc_pad_s;
endpackage : spc_pkg

// ===== core/spc_pin_ctrl.sv
// standby pin state control: pad drive and input gating per power state
// the block sits between the port logic and the pads; every output is
// registered, so a pad or input change shows one clock after the request
// that causes it.
// hazard: standby is decoded from the live requests, not from a mode
// register, so the first standby cycle still copies the pad register as it
// stood in run and nothing glitches on entry.
// limitation: select low freezes out, oe and pull-up together; a pull-up
// change asked for during stop or watch with select low only lands after wake-up.
// reset floats every pad without pull-up; the input buffers may toggle,
// but nothing downstream sees them until one clock after release.
`timescale 1ns/10ps
`default_nettype none
`include "spc_params.svh"
module spc_pin_ctrl
  import spc_pkg::*;
#(
  parameter int NPINS   = `SPC_NUM_PINS,
  parameter int CH9_PIN = 1
)(
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  // power state control
  input  wire logic                  stopReq,
  input  wire logic                  watchReq,
  input  wire logic                  sleepReq,
  input  wire logic                  standby_pin_level_select,
  // port and peripheral side
  input  wire spc_drive_s [NPINS-1:0] pinDrive,
  input  wire logic [NPINS-1:0]      extIrqEn,
  output var  logic [NPINS-1:0]      pinInFunc,
  output var  logic [NPINS-1:0]      pinInIrq,
  output var  logic                  ext_irq_ch9_input,
  // pad side and registered power state
  input  wire logic [NPINS-1:0]      padIn,
  output var  spc_pad_s [NPINS-1:0]  padDrive,
  output var  spc_mode_e             modeOut
);

  // ****************************************
  // power state
  // ****************************************
  spc_mode_e modeD;
  logic      resetHeldQ;

  // next mode from requests; stop wins over watch, watch over sleep
  always_comb
  begin
    if (stopReq)       modeD = SPC_STOP;
    else if (watchReq) modeD = SPC_WATCH;
    else if (sleepReq) modeD = SPC_SLEEP;
    else               modeD = SPC_RUN;
  end

  // reset marker; stays up for the first clock after release
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      resetHeldQ <= 1'h1;
    end
    else
    begin
      resetHeldQ <= 1'h0;
    end
  end

  wire logic standby = (modeD == SPC_STOP) || (modeD == SPC_WATCH);

  // ****************************************
  // per-pin drive and input gating
  // ****************************************
  spc_pad_s [NPINS-1:0] padD;
  logic     [NPINS-1:0] inFuncD;
  logic     [NPINS-1:0] inIrqD;

  genvar g;
  generate
    for (g = 0; g < NPINS; g++)
    begin : gPin
      // output path per state
      always_comb
      begin
        padD[g] = padDrive[g];
        if (!standby)
          padD[g] = pinDrive[g];
        else if (standby_pin_level_select)
        begin
          padD[g].oe  = 1'h0;
          padD[g].out = padDrive[g].out;
          padD[g].pu  = pinDrive[g].pu;
        end
        // select low holds the previous pad drive unchanged
        inFuncD[g] = standby ? 1'h0 : padIn[g];
        inIrqD[g]  = (!standby || extIrqEn[g]) ? padIn[g] : 1'h0;
      end
    end
  endgenerate

  // pad and input registers; reset floats all pins and forces inputs idle
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < NPINS; i++)
      begin
        padDrive[i].out <= `SPC_RST_OUT;
        padDrive[i].oe  <= `SPC_RST_OE;
        padDrive[i].pu  <= `SPC_RST_PU;
      end
      pinInFunc         <= '0;
      pinInIrq          <= '0;
      ext_irq_ch9_input <= `SPC_RST_IN;
      modeOut           <= SPC_RESET;
    end
    else
    begin
      padDrive          <= padD;
      pinInFunc         <= inFuncD;
      pinInIrq          <= inIrqD;
      ext_irq_ch9_input <= inIrqD[CH9_PIN];
      modeOut           <= modeD;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  // the first clock after release is still a reset clock, so it is masked too

  // select high: no pad is driven one clock into standby
  a_hiz_select_high: assert property (
    @(posedge mclk) disable iff (sys_rst || resetHeldQ)
    standby && standby_pin_level_select |=> (padDrive & {NPINS{3'h2}}) == '0)
    else $error("pad driven in standby with select high");

  // select low: the whole pad register stays frozen
  a_hold_select_low: assert property (
    @(posedge mclk) disable iff (sys_rst || resetHeldQ)
    standby && !standby_pin_level_select |=> padDrive == $past(padDrive))
    else $error("pad drive changed in standby with select low");

  // port and peripheral inputs are cut in stop and watch
  a_block_inputs: assert property (
    @(posedge mclk) disable iff (sys_rst || resetHeldQ)
    standby |=> pinInFunc == '0)
    else $error("input passed in standby");

  // in stop and watch, interrupt inputs pass only where the request is enabled
  a_irq_pass: assert property (
    @(posedge mclk) disable iff (sys_rst || resetHeldQ)
    standby |=> pinInIrq == ($past(padIn) & $past(extIrqEn)))
    else $error("interrupt input gating wrong");

  // channel 9 still reaches its interrupt logic when enabled
  a_ch9_pass: assert property (
    @(posedge mclk) disable iff (sys_rst || resetHeldQ)
    standby && extIrqEn[CH9_PIN] |=> ext_irq_ch9_input == $past(padIn[CH9_PIN]))
    else $error("channel 9 interrupt not passed");

  // run and sleep pass drive and input straight through
  a_sleep_same: assert property (
    @(posedge mclk) disable iff (sys_rst || resetHeldQ)
    !standby |=> padDrive == $past(pinDrive) && pinInFunc == $past(padIn))
    else $error("sleep or run drive differs");

  // during reset and its first clock out, everything floats and stays quiet
  a_reset_float: assert property (
    @(posedge mclk)
    resetHeldQ |-> padDrive == '0 && pinInFunc == '0 && pinInIrq == '0
      && !ext_irq_ch9_input && modeOut == SPC_RESET)
    else $error("pins not floating after reset");

  // select high: pull-up follows the port logic on every pin
  a_pu_kept: assert property (
    @(posedge mclk) disable iff (sys_rst || resetHeldQ)
    standby && standby_pin_level_select
      |=> (padDrive & {NPINS{3'h1}}) == ($past(pinDrive) & {NPINS{3'h1}}))
    else $error("pull-up lost in standby");

  // select high: the output level bit is kept for wake-up
  a_out_kept_hiz: assert property (
    @(posedge mclk) disable iff (sys_rst || resetHeldQ)
    standby && standby_pin_level_select
      |=> (padDrive & {NPINS{3'h4}}) == ($past(padDrive) & {NPINS{3'h4}}))
    else $error("output level lost in standby");

  // the shared clock and interrupt pin floats with select high
  a_ch9_float: assert property (
    @(posedge mclk) disable iff (sys_rst || resetHeldQ)
    standby && standby_pin_level_select |=> !padDrive[CH9_PIN].oe)
    else $error("channel 9 pin driven in standby");

  // a disabled channel 9 stays silent in standby
  a_ch9_blocked: assert property (
    @(posedge mclk) disable iff (sys_rst || resetHeldQ)
    standby && !extIrqEn[CH9_PIN] |=> !ext_irq_ch9_input)
    else $error("channel 9 passed while disabled");

  // outside standby the interrupt paths see the pads as they are
  a_irq_free_run: assert property (
    @(posedge mclk) disable iff (sys_rst || resetHeldQ)
    !standby |=> pinInIrq == $past(padIn))
    else $error("interrupt input gated outside standby");

  // channel 9 follows its pad outside standby
  a_ch9_run: assert property (
    @(posedge mclk) disable iff (sys_rst || resetHeldQ)
    !standby |=> ext_irq_ch9_input == $past(padIn[CH9_PIN]))
    else $error("channel 9 gated outside standby");

  // sleep alone shows as sleep mode
  a_sleep_mode: assert property (
    @(posedge mclk) disable iff (sys_rst || resetHeldQ)
    sleepReq && !stopReq && !watchReq |=> modeOut == SPC_SLEEP)
    else $error("sleep mode not shown");

  // stop beats every other request
  a_stop_mode: assert property (
    @(posedge mclk) disable iff (sys_rst || resetHeldQ)
    stopReq |=> modeOut == SPC_STOP)
    else $error("stop mode not shown");

  // watch beats sleep
  a_watch_mode: assert property (
    @(posedge mclk) disable iff (sys_rst || resetHeldQ)
    watchReq && !stopReq |=> modeOut == SPC_WATCH)
    else $error("watch mode not shown");

  // per-pin view of the same rules, so a failure names the pin
  generate
    for (g = 0; g < NPINS; g++)
    begin : gChk
      // select high: this pin is released
      a_pin_oe_off: assert property (
        @(posedge mclk) disable iff (sys_rst || resetHeldQ)
        standby && standby_pin_level_select |=> !padDrive[g].oe)
        else $error("pin driven in standby with select high");

      // select low: this pin keeps its drive
      a_pin_held: assert property (
        @(posedge mclk) disable iff (sys_rst || resetHeldQ)
        standby && !standby_pin_level_select |=> padDrive[g] == $past(padDrive[g]))
        else $error("pin drive changed in standby with select low");

      // a pin without enabled interrupt passes nothing in standby
      a_pin_blocked: assert property (
        @(posedge mclk) disable iff (sys_rst || resetHeldQ)
        standby && !extIrqEn[g] |=> !pinInIrq[g] && !pinInFunc[g])
        else $error("pin input passed in standby");
    end
  endgenerate

endmodule : spc_pin_ctrl
`default_nettype wire

// ===== verification/spc_board_model.sv
// board side model of the port pads
`timescale 1ns/10ps
`default_nettype none
module spc_board_model import spc_pkg::*; (
  // clock and pads
  input  wire logic           mclk,
  input  wire spc_pad_s [7:0] padDrive,
  output var  logic [7:0]     padIn
);
  logic wander_q = 1'b0;
  // a floating line without pull-up shows a new level each cycle
  always_ff @(posedge mclk) wander_q <= !wander_q;
  // driven level first, then pull-up, else the wandering level
  always_comb
    for (int i = 0; i < 8; i++)
      padIn[i] = padDrive[i].oe ? padDrive[i].out : padDrive[i].pu | wander_q;
endmodule : spc_board_model
`default_nettype wire

// ===== verification/testbench.sv
// bench for the standby pin state control block
`timescale 1ns/10ps
`default_nettype none
module testbench import spc_pkg::*; ;
  logic             mclk = 1'b0, sysRst = 1'b1, ch9;
  logic [35:0]      stim = '0;
  logic [7:0]       padIn, inFunc, inIrq;
  spc_pad_s [7:0]   padDrive;
  spc_mode_e        modeOut;
  int               n_mismatch = 0, cmp_count = 0;
  localparam logic [23:0] D1 = 24'h34dcb2, D2 = 24'hcb234d;
  // 10 MHz clock
  always #50 mclk = !mclk;
  spc_pin_ctrl i_spc_pin_ctrl (.mclk(mclk), .sys_rst(sysRst), .stopReq(stim[35]),
    .watchReq(stim[34]), .sleepReq(stim[33]), .standby_pin_level_select(stim[32]),
    .pinDrive(stim[31:8]), .extIrqEn(stim[7:0]), .pinInFunc(inFunc), .pinInIrq(inIrq),
    .ext_irq_ch9_input(ch9), .padIn(padIn), .padDrive(padDrive), .modeOut(modeOut));
  spc_board_model i_spc_board_model (.mclk(mclk), .padDrive(padDrive), .padIn(padIn));
  task automatic chk(input string nm, input logic [47:0] exp, got);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  // apply one stimulus word after an edge, look once the next edge took it
  task automatic go(input logic [35:0] s);
    @(posedge mclk);
    stim <= s;
    @(posedge mclk) #1;
  endtask : go
  // run or sleep, then stop or watch at both select levels
  task automatic standby;
    for (int k = 0; k < 4; k++)
    begin
      repeat (2) go({2'b00, k[0], k[0], D1, 8'h03});
      chk("run", {D1, 8'hfa, 8'hfa, 1'b1, k[0] ? SPC_SLEEP : SPC_RUN},
        {padDrive, inFunc, inIrq, ch9, modeOut});
      go({k[1], !k[1], 1'b0, k[0], D2, 8'h03});
      chk("pads", k[0] ? 24'h104a69 : D1, padDrive);
      chk("func", {8'h00, k[1] ? SPC_STOP : SPC_WATCH}, {inFunc, modeOut});
      go({k[1], !k[1], 1'b0, k[0], D2, 8'h03});
      chk("irq", {k[0] ? 8'h03 : 8'h02, 1'b1}, {inIrq, ch9});
      go({k[1], !k[1], 1'b0, k[0], D2, 8'h00});
      chk("irq off", 9'h0, {inIrq, ch9});
    end
  endtask : standby
  // reset in mid-run floats every pad and mutes all inputs
  task automatic reset_float;
    go({4'h0, 24'hffffff, 8'hff});
    @(posedge mclk);
    sysRst <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk("reset", {24'h0, 17'h0, SPC_RESET}, {padDrive, inFunc, inIrq, ch9, modeOut});
    @(posedge mclk);
    sysRst <= 1'b0;
    // first clock out of reset follows the old word, the second the new one
    go({4'h0, D1, 8'h03});
    chk("after reset", {D1, 8'hff, SPC_RUN}, {padDrive, inFunc, modeOut});
  endtask : reset_float
  task automatic wrap_up;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  // hold reset for 16 cycles, then run the scenarios
  initial
  begin
    repeat (16) @(posedge mclk);
    sysRst <= 1'b0;
    standby();
    reset_float();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
